// ===== verilog/hcmr_consts.vh
// Constants for the host control and mailbox register bank
`ifndef HCMR_CONSTS_VH
`define HCMR_CONSTS_VH
`define HCMR_OFF_PAGE 8'h85
`define HCMR_OFF_BOX 8'h86
`define HCMR_OFF_HCTL 8'h87
`define HCMR_OFF_HADDR_LO 8'h88
`define HCMR_OFF_HADDR_HI 8'h8B
`define HCMR_OFF_SHADOW_HOST_ADDRESS_LO 8'h14
`define HCMR_OFF_SHADOW_HOST_ADDRESS_HI 8'h17
`define HCMR_PAGE_LOW 2'h0
`define HCMR_PAGE_HIGH 2'h1
`define HCMR_PAGE_MASK 8'h03
`define HCMR_PAGE_MSB 1
`define HCMR_PAGE_LSB 0
`define HCMR_BOX_HOST_MSB 7
`define HCMR_BOX_HOST_LSB 4
`define HCMR_BIT_PWRDN 6
`define HCMR_BIT_SWIRQ 4
`define HCMR_BIT_SPARE 3
`define HCMR_BIT_HALT 2
`define HCMR_BIT_IRQEN 1
`define HCMR_BIT_RST 0
`define HCMR_HCTL_RST_REQ 1'h1
`define HCMR_HALT_RST 1'h1
`define HCMR_RDATA_RST 8'h00
`endif

// ===== verilog/hcmr_nibble.v
// Nibble-wide storage cell with its own write strobe
`timescale 1ns/1ps
module hcmr_nibble #(
    parameter W = 4
)(
    input wire clk,
    input wire clr,
    input wire we,
    input wire [W-1:0] din,
    output reg [W-1:0] q
);
    always @(posedge clk)
    begin
        if (clr)
            q <= {W{1'b0}};
        else if (we)
            q <= din;
    end
endmodule

// ===== verilog/hcmr_regs.v
// Host control, page select and mailbox register bank
`timescale 1ns/1ps
`include "hcmr_consts.vh"
module hcmr_regs (
    input wire MCLK,
    input wire RST_N,
    input wire HOST_WR,
    input wire HOST_RD,
    input wire [7:0] HOST_ADDR,
    input wire [7:0] HOST_WDATA,
    output reg [7:0] HOST_RDATA,
    output wire HOST_RD_WAIT,
    output wire HOST_SEQ_ACCESS_OK,
    input wire SEQ_BOX_WR,
    input wire [3:0] SEQ_BOX_WDATA,
    output wire [3:0] SEQ_HOST_NIBBLE,
    input wire HALT_ACK_IN,
    output wire HALT_REQ,
    input wire IRQ_PENDING,
    input wire BUS_MASTER_ENABLE,
    input wire MEM_SPACE_ENABLE,
    input wire IO_SPACE_ENABLE,
    output reg IRQ_OUT_N,
    output wire MAIN_CLOCK_GATE,
    output wire SCSI_INPUT_ISOLATE,
    output wire DEVICE_RESET,
    output wire [1:0] ADDR_PAGE_FIELD,
    output wire HADDR_PAGE_HIGH,
    output wire SHADOW_HOST_ADDRESS_PAGE_HIGH
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Every level here comes from another domain; only second flops feed logic
    reg halt_ack_s1;
    reg halt_ack;
    reg master_s1;
    reg master_on;
    reg mem_s1;
    reg mem_on;
    reg io_s1;
    reg io_on;
    reg irq_s1;
    reg irq_pend;
    always @(posedge MCLK)
    begin
        halt_ack_s1 <= HALT_ACK_IN;
        halt_ack <= halt_ack_s1;
        master_s1 <= BUS_MASTER_ENABLE;
        master_on <= master_s1;
        mem_s1 <= MEM_SPACE_ENABLE;
        mem_on <= mem_s1;
        io_s1 <= IO_SPACE_ENABLE;
        io_on <= io_s1;
        irq_s1 <= IRQ_PENDING;
        irq_pend <= irq_s1;
    end

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    reg [1:0] addr_page_field;
    reg power_down_bit;
    reg software_irq_bit;
    reg spare_bit;
    reg halt_req;
    reg irq_enable_bit;
    reg soft_device_reset;
    reg device_reset_flag;
    reg read_pending;
    reg page_high;
    reg [7:0] hctl_view;
    wire wr_page = HOST_WR && (HOST_ADDR == `HCMR_OFF_PAGE);
    wire wr_box = HOST_WR && (HOST_ADDR == `HCMR_OFF_BOX);
    wire wr_hctl = HOST_WR && (HOST_ADDR == `HCMR_OFF_HCTL);
    wire rd_hctl = HOST_RD && (HOST_ADDR == `HCMR_OFF_HCTL);
    // Soft reset clears everything but the input synchronisers, HOST_RDATA, IRQ_OUT_N, itself and its flag
    wire clr_all = !RST_N || soft_device_reset;
    // Sequencer write cannot land on the host nibble
    wire [3:0] host_nib;
    wire [3:0] seq_nib;

    // ----------------------------------------
    // Mailbox
    // ----------------------------------------
    hcmr_nibble #(.W(4)) u_host_nib (
        .clk(MCLK),
        .clr(clr_all),
        .we(wr_box),
        .din(HOST_WDATA[`HCMR_BOX_HOST_MSB:`HCMR_BOX_HOST_LSB]),
        .q(host_nib)
    );
    hcmr_nibble #(.W(4)) u_seq_nib (
        .clk(MCLK),
        .clr(clr_all),
        .we(SEQ_BOX_WR),
        .din(SEQ_BOX_WDATA),
        .q(seq_nib)
    );
    assign SEQ_HOST_NIBBLE = host_nib;

    // ----------------------------------------
    // Page select and host control
    // ----------------------------------------
    wire next_halt = HOST_WDATA[`HCMR_BIT_HALT] ||
        (HOST_WDATA[`HCMR_BIT_PWRDN] && halt_req);
    always @(posedge MCLK)
    begin
        if (clr_all)
        begin
            addr_page_field <= `HCMR_PAGE_LOW;
            page_high <= 1'b0;
            power_down_bit <= 1'b0;
            software_irq_bit <= 1'b0;
            spare_bit <= 1'b0;
            irq_enable_bit <= 1'b0;
            halt_req <= `HCMR_HALT_RST;
        end
        else
        begin
            if (wr_page)
            begin
                addr_page_field <= HOST_WDATA[`HCMR_PAGE_MSB:`HCMR_PAGE_LSB];
                // Decoded here so both page outputs leave from a flop
                page_high <= (HOST_WDATA[`HCMR_PAGE_MSB:`HCMR_PAGE_LSB] == `HCMR_PAGE_HIGH);
            end
            if (wr_hctl)
            begin
                power_down_bit <= HOST_WDATA[`HCMR_BIT_PWRDN];
                software_irq_bit <= HOST_WDATA[`HCMR_BIT_SWIRQ];
                spare_bit <= HOST_WDATA[`HCMR_BIT_SPARE];
                irq_enable_bit <= HOST_WDATA[`HCMR_BIT_IRQEN];
                halt_req <= next_halt;
            end
        end
    end

    // Reset pulse and its flag live outside the soft reset so the flag holds
    always @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            soft_device_reset <= 1'b0;
            device_reset_flag <= `HCMR_HCTL_RST_REQ;
        end
        else
        begin
            soft_device_reset <= wr_hctl && HOST_WDATA[`HCMR_BIT_RST];
            if (wr_hctl)
                device_reset_flag <= HOST_WDATA[`HCMR_BIT_RST];
        end
    end

    // ----------------------------------------
    // Read stretch after a halt change
    // ----------------------------------------
    always @(posedge MCLK)
    begin
        if (clr_all)
            read_pending <= 1'b0;
        // A fresh halt change wins over the acknowledge-match clear in the same cycle, but clr_all wins over both
        else if (wr_hctl && (next_halt != halt_req))
            read_pending <= 1'b1;
        else if (halt_ack == halt_req)
            read_pending <= 1'b0;
    end
    // Wait stays up only while the acknowledge still lags the request
    assign HOST_RD_WAIT = rd_hctl && read_pending && (halt_ack != halt_req);

    // ----------------------------------------
    // Host control read view
    // ----------------------------------------
    // Bits are placed by position so reserved ones default to zero
    always @*
    begin
        hctl_view = `HCMR_RDATA_RST;
        hctl_view[`HCMR_BIT_PWRDN] = power_down_bit;
        hctl_view[`HCMR_BIT_SWIRQ] = software_irq_bit;
        hctl_view[`HCMR_BIT_SPARE] = spare_bit;
        hctl_view[`HCMR_BIT_HALT] = halt_ack;
        hctl_view[`HCMR_BIT_IRQEN] = irq_enable_bit;
        hctl_view[`HCMR_BIT_RST] = device_reset_flag;
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @(posedge MCLK)
    begin
        if (!RST_N)
            HOST_RDATA <= `HCMR_RDATA_RST;
        else if (HOST_RD)
        begin
            case (HOST_ADDR)
                `HCMR_OFF_PAGE: HOST_RDATA <= {6'h00, addr_page_field};
                `HCMR_OFF_BOX: HOST_RDATA <= {host_nib, seq_nib};
                `HCMR_OFF_HCTL: HOST_RDATA <= hctl_view;
                default: HOST_RDATA <= `HCMR_RDATA_RST;
            endcase
        end
    end

    // ----------------------------------------
    // Interrupt, power and access gating
    // ----------------------------------------
    // Power-down wins over every source, including the software request
    wire space_on = mem_on || io_on;
    wire irq_next = !power_down_bit && irq_enable_bit && master_on &&
        (irq_pend || (software_irq_bit && space_on));
    always @(posedge MCLK)
    begin
        if (!RST_N)
            IRQ_OUT_N <= 1'b1;
        else
            IRQ_OUT_N <= !irq_next;
    end
    assign MAIN_CLOCK_GATE = power_down_bit;
    assign SCSI_INPUT_ISOLATE = power_down_bit;
    // Sequencer-owned space is shut while unpaused or powered down
    assign HOST_SEQ_ACCESS_OK = halt_req && halt_ack && !power_down_bit;
    assign HALT_REQ = halt_req;
    assign DEVICE_RESET = soft_device_reset;
    assign ADDR_PAGE_FIELD = addr_page_field;
    assign HADDR_PAGE_HIGH = page_high;
    assign SHADOW_HOST_ADDRESS_PAGE_HIGH = page_high;
endmodule

// ===== testbench/hcmr_regs_properties.sv
// Port checks for the host control and mailbox register bank
`timescale 1ns/1ps
module hcmr_regs_properties (
    input wire MCLK,
    input wire RST_N,
    input wire HOST_WR,
    input wire HOST_RD,
    input wire [7:0] HOST_ADDR,
    input wire [7:0] HOST_WDATA,
    input wire [7:0] HOST_RDATA,
    input wire HOST_SEQ_ACCESS_OK,
    input wire SEQ_BOX_WR,
    input wire [3:0] SEQ_HOST_NIBBLE,
    input wire HALT_REQ,
    input wire IRQ_OUT_N,
    input wire MAIN_CLOCK_GATE,
    input wire SCSI_INPUT_ISOLATE,
    input wire DEVICE_RESET,
    input wire [1:0] ADDR_PAGE_FIELD,
    input wire HADDR_PAGE_HIGH,
    input wire SHADOW_HOST_ADDRESS_PAGE_HIGH
);
default clocking @(posedge MCLK); endclocking
default disable iff (!RST_N);
// Soft reset clears the page, mailbox and control registers, so writes in its cycle prove nothing
sequence wr_at(a);
    HOST_WR && HOST_ADDR == a && !DEVICE_RESET;
endsequence
a_page_decode: assert property (HADDR_PAGE_HIGH == (ADDR_PAGE_FIELD == 2'h1)
    && SHADOW_HOST_ADDRESS_PAGE_HIGH == HADDR_PAGE_HIGH) else $error("page decode wrong");
a_page_write: assert property (wr_at(8'h85) |=> ADDR_PAGE_FIELD == $past(HOST_WDATA[1:0]))
    else $error("page field not written");
a_host_nibble: assert property (wr_at(8'h86) |=> SEQ_HOST_NIBBLE == $past(HOST_WDATA[7:4]))
    else $error("host nibble not written");
a_seq_keeps: assert property (SEQ_BOX_WR && !HOST_WR && !DEVICE_RESET |=>
    $stable(SEQ_HOST_NIBBLE)) else $error("sequencer write hit host nibble");
a_pwrdn_pins: assert property (MAIN_CLOCK_GATE == SCSI_INPUT_ISOLATE)
    else $error("power-down outputs disagree");
a_pwrdn_irq: assert property (MAIN_CLOCK_GATE && $past(MAIN_CLOCK_GATE) |-> IRQ_OUT_N)
    else $error("interrupt during power-down");
a_pwrdn_access: assert property (MAIN_CLOCK_GATE |-> !HOST_SEQ_ACCESS_OK)
    else $error("sequencer access during power-down");
a_halt_interlock: assert property (wr_at(8'h87) ##0 (HOST_WDATA[6] && !HOST_WDATA[2]
    && HALT_REQ) |=> HALT_REQ) else $error("power-down write cleared halt");
a_rsvd_zero: assert property (HOST_RD && HOST_ADDR == 8'h85 |=> HOST_RDATA[7:2] == 6'h00)
    else $error("reserved page bits read nonzero");
endmodule
bind hcmr_regs hcmr_regs_properties chk_u (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .HOST_WR(HOST_WR),
    .HOST_RD(HOST_RD),
    .HOST_ADDR(HOST_ADDR),
    .HOST_WDATA(HOST_WDATA),
    .HOST_RDATA(HOST_RDATA),
    .HOST_SEQ_ACCESS_OK(HOST_SEQ_ACCESS_OK),
    .SEQ_BOX_WR(SEQ_BOX_WR),
    .SEQ_HOST_NIBBLE(SEQ_HOST_NIBBLE),
    .HALT_REQ(HALT_REQ),
    .IRQ_OUT_N(IRQ_OUT_N),
    .MAIN_CLOCK_GATE(MAIN_CLOCK_GATE),
    .SCSI_INPUT_ISOLATE(SCSI_INPUT_ISOLATE),
    .DEVICE_RESET(DEVICE_RESET),
    .ADDR_PAGE_FIELD(ADDR_PAGE_FIELD),
    .HADDR_PAGE_HIGH(HADDR_PAGE_HIGH),
    .SHADOW_HOST_ADDRESS_PAGE_HIGH(SHADOW_HOST_ADDRESS_PAGE_HIGH)
);

// ===== testbench/hcmr_seq_model.sv
// Sequencer-side model: halt acknowledge and lower mailbox nibble
`timescale 1ns/1ps
module hcmr_seq_model #(
    parameter ACK_DELAY = 3
)(
    input wire clk,
    input wire halt_req,
    output wire halt_ack,
    output reg box_wr,
    output reg [3:0] box_data
);
reg [7:0] pipe = 8'h00;
assign halt_ack = pipe[ACK_DELAY-1];
always @(posedge clk)
begin
    pipe <= {pipe[6:0], halt_req};
end
task put(input [3:0] n);
begin
    @(posedge clk);
    box_wr <= 1'b1;
    box_data <= n;
    @(posedge clk);
    box_wr <= 1'b0;
    box_data <= ~n; // Stale data must not look like a repeat
end
endtask
initial box_wr = 1'b0;
initial box_data = 4'h0;
endmodule

// ===== testbench/hcmr_regs_tb_top.sv
// Self-checking bench for the host control and mailbox register bank
`timescale 1ns/1ps
module hcmr_regs_tb_top;
reg MCLK = 1'b0;
reg RST_N = 1'b0;
reg HOST_WR = 1'b0;
reg HOST_RD = 1'b0;
reg [7:0] HOST_ADDR = 8'h00;
reg [7:0] HOST_WDATA = 8'h00;
reg IRQ_PENDING = 1'b0;
reg BUS_MASTER_ENABLE = 1'b0;
reg MEM_SPACE_ENABLE = 1'b0;
reg IO_SPACE_ENABLE = 1'b0;
reg seen_rst = 1'b0;
integer n_mismatch = 0;
integer n_compared = 0;
integer cycles = 0;
integer n_wait = 0;
wire [7:0] HOST_RDATA;
wire [3:0] SEQ_BOX_WDATA, SEQ_HOST_NIBBLE;
wire [1:0] ADDR_PAGE_FIELD;
wire HOST_RD_WAIT, HOST_SEQ_ACCESS_OK, SEQ_BOX_WR, HALT_ACK_IN, HALT_REQ, IRQ_OUT_N;
wire MAIN_CLOCK_GATE, SCSI_INPUT_ISOLATE, DEVICE_RESET, HADDR_PAGE_HIGH, SHADOW_HOST_ADDRESS_PAGE_HIGH;
hcmr_regs dut_u (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .HOST_WR(HOST_WR),
    .HOST_RD(HOST_RD),
    .HOST_ADDR(HOST_ADDR),
    .HOST_WDATA(HOST_WDATA),
    .HOST_RDATA(HOST_RDATA),
    .HOST_RD_WAIT(HOST_RD_WAIT),
    .HOST_SEQ_ACCESS_OK(HOST_SEQ_ACCESS_OK),
    .SEQ_BOX_WR(SEQ_BOX_WR),
    .SEQ_BOX_WDATA(SEQ_BOX_WDATA),
    .SEQ_HOST_NIBBLE(SEQ_HOST_NIBBLE),
    .HALT_ACK_IN(HALT_ACK_IN),
    .HALT_REQ(HALT_REQ),
    .IRQ_PENDING(IRQ_PENDING),
    .BUS_MASTER_ENABLE(BUS_MASTER_ENABLE),
    .MEM_SPACE_ENABLE(MEM_SPACE_ENABLE),
    .IO_SPACE_ENABLE(IO_SPACE_ENABLE),
    .IRQ_OUT_N(IRQ_OUT_N),
    .MAIN_CLOCK_GATE(MAIN_CLOCK_GATE),
    .SCSI_INPUT_ISOLATE(SCSI_INPUT_ISOLATE),
    .DEVICE_RESET(DEVICE_RESET),
    .ADDR_PAGE_FIELD(ADDR_PAGE_FIELD),
    .HADDR_PAGE_HIGH(HADDR_PAGE_HIGH),
    .SHADOW_HOST_ADDRESS_PAGE_HIGH(SHADOW_HOST_ADDRESS_PAGE_HIGH)
);
hcmr_seq_model seq_u (.clk(MCLK), .halt_req(HALT_REQ), .halt_ack(HALT_ACK_IN),
    .box_wr(SEQ_BOX_WR), .box_data(SEQ_BOX_WDATA));
initial forever #2 MCLK = ~MCLK;
task chk(input string what, input [7:0] seen, input [7:0] exp);
begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
end
endtask
task wr(input [7:0] a, input [7:0] v);
begin
    @(posedge MCLK);
    HOST_WR <= 1'b1;
    HOST_ADDR <= a;
    HOST_WDATA <= v;
    @(posedge MCLK);
    HOST_WR <= 1'b0;
    @(negedge MCLK);
end
endtask
// Held read repeats while the stretch is up; the last taken read wins
task rd(input [7:0] a, input [7:0] e);
begin
    @(posedge MCLK);
    HOST_RD <= 1'b1;
    HOST_ADDR <= a;
    @(negedge MCLK);
    while (HOST_RD_WAIT)
    begin
        n_wait = n_wait + 1;
        @(negedge MCLK);
    end
    @(posedge MCLK);
    HOST_RD <= 1'b0;
    @(negedge MCLK);
    chk("read data", HOST_RDATA, e);
end
endtask
task complete_run;
begin
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
end
endtask
always @(posedge MCLK)
begin
    cycles <= cycles + 1;
    if (DEVICE_RESET === 1'b1)
        seen_rst <= 1'b1;
    if (cycles == 3000)
    begin
        n_mismatch = n_mismatch + 1;
        complete_run;
    end
end
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial
begin
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (8) @(negedge MCLK);
    rd(8'h85, 8'h00);
    rd(8'h86, 8'h00);
    rd(8'h87, 8'h05);
    wr(8'h85, 8'hFF);
    rd(8'h85, 8'h03);
    chk("page high", {7'h00, HADDR_PAGE_HIGH}, 8'h00);
    wr(8'h85, 8'h01);
    chk("shadow high", {7'h00, SHADOW_HOST_ADDRESS_PAGE_HIGH}, 8'h01);
    chk("host page high", {7'h00, HADDR_PAGE_HIGH}, 8'h01);
    chk("page field", {6'h00, ADDR_PAGE_FIELD}, 8'h01);
    seq_u.put(4'hA);
    wr(8'h86, 8'h5C);
    rd(8'h86, 8'h5A);
    chk("host nibble", {4'h0, SEQ_HOST_NIBBLE}, 8'h05);
    seq_u.put(4'h3);
    rd(8'h86, 8'h53);
    wr(8'h87, 8'h08);
    rd(8'h87, 8'h08);
    chk("stretch", {7'h00, (n_wait != 0)}, 8'h01);
    @(posedge MCLK);
    BUS_MASTER_ENABLE <= 1'b1;
    MEM_SPACE_ENABLE <= 1'b1;
    wr(8'h87, 8'h1A);
    repeat (6) @(negedge MCLK);
    chk("irq", {7'h00, IRQ_OUT_N}, 8'h00);
    rd(8'h87, 8'h1A);
    @(posedge MCLK);
    IRQ_PENDING <= 1'b1;
    wr(8'h87, 8'h0A);
    repeat (6) @(negedge MCLK);
    chk("irq", {7'h00, IRQ_OUT_N}, 8'h00);
    wr(8'h87, 8'h04);
    rd(8'h87, 8'h04);
    wr(8'h87, 8'h52);
    repeat (6) @(negedge MCLK);
    chk("halt", {7'h00, HALT_REQ}, 8'h01);
    chk("gate", {6'h00, MAIN_CLOCK_GATE, SCSI_INPUT_ISOLATE}, 8'h03);
    chk("irq", {7'h00, IRQ_OUT_N}, 8'h01);
    chk("access", {7'h00, HOST_SEQ_ACCESS_OK}, 8'h00);
    wr(8'h87, 8'hA6);
    repeat (3) @(negedge MCLK);
    chk("access", {7'h00, HOST_SEQ_ACCESS_OK}, 8'h01);
    rd(8'h87, 8'h06);
    wr(8'h87, 8'h01);
    repeat (8) @(negedge MCLK);
    chk("soft reset", {7'h00, seen_rst}, 8'h01);
    rd(8'h85, 8'h00);
    rd(8'h87, 8'h05);
    complete_run;
end
endmodule
